// file: mtl_pkg.sv
// Purpose: Shared constants and types for the memory type range lookup block
// Assumes: Registers are reached through a model-specific register port
// Notes:   Register indices and reset values are named here and nowhere else
`default_nettype none
package mtl_pkg;
  // Physical address and field widths
  localparam int PA_W  = 52;
  localparam int PFN_W = 40;
  localparam int TYP_W = 8;
  localparam int DAT_W = 64;
  localparam int IDX_W = 8;

  // Register indices on the model-specific register port
  localparam logic [IDX_W-1:0] IDX_VAR_FIRST = 8'h00; // base n at 2n, mask n at 2n+1
  localparam logic [IDX_W-1:0] IDX_FIX_E8    = 8'h10;
  localparam logic [IDX_W-1:0] IDX_FIX_F0    = 8'h11;
  localparam logic [IDX_W-1:0] IDX_FIX_F8    = 8'h12;
  localparam logic [IDX_W-1:0] IDX_DEF_TYPE  = 8'h13;

  // Field positions
  localparam int TYPE_LSB  = 0;
  localparam int PFN_LSB   = 12;
  localparam int PFN_MSB   = 51;
  localparam int MASK_V    = 11;
  localparam int DEF_FE    = 10;
  localparam int DEF_GE    = 11;

  // Fixed 4-Kbyte regions: 32-Kbyte blocks E8, F0, F8 of the first megabyte
  localparam logic [4:0] FIX_FIRST_BLK = 5'h1d;
  localparam int         FIX_REGS      = 3;

  // Memory type encodings
  localparam logic [TYP_W-1:0] MT_UC = 8'h00;
  localparam logic [TYP_W-1:0] MT_WC = 8'h01;
  localparam logic [TYP_W-1:0] MT_WT = 8'h04;
  localparam logic [TYP_W-1:0] MT_WP = 8'h05;
  localparam logic [TYP_W-1:0] MT_WB = 8'h06;

  // Reset values
  localparam logic [TYP_W-1:0] RST_TYPE = 8'h00;
  localparam logic [PFN_W-1:0] RST_PFN  = 40'h00_0000_0000;
  localparam logic [DAT_W-1:0] RST_FIX  = 64'h0000_0000_0000_0000;

  // Register access request and answer
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [IDX_W-1:0] idx;
    logic [DAT_W-1:0] data;
  } mtl_msr_req_t;

  typedef struct packed {
    logic             ack;
    logic             fault;
    logic [DAT_W-1:0] rdata;
  } mtl_msr_rsp_t;

  // True for the standard type encodings only
  function automatic logic type_ok(input logic [TYP_W-1:0] t);
    return (t == MT_UC) || (t == MT_WC) || (t == MT_WT) || (t == MT_WP) || (t == MT_WB);
  endfunction
endpackage
`default_nettype wire

// file: mtl_range_match.sv
// Purpose: Match one physical page number against one base and mask pair
// Assumes: Page offset bits are dropped by the caller
// Notes:   Purely combinational; one instance per variable range
`timescale 1ns/1ps
`default_nettype none
module mtl_range_match (
  input  wire logic [mtl_pkg::PFN_W-1:0] base_i,
  input  wire logic [mtl_pkg::PFN_W-1:0] mask_i,
  input  wire logic                      valid_i,
  input  wire logic [mtl_pkg::PFN_W-1:0] pfn_i,
  output logic                           hit_o
);
  // Low 12 bits of base and mask are implicitly zero, so only page numbers compare
  assign hit_o = valid_i && ((mask_i & base_i) == (mask_i & pfn_i));
endmodule
`default_nettype wire

// file: mtl_lookup.sv
// Purpose: Memory type range lookup with fixed, variable and default types
// Assumes: Requests and register accesses are synchronous to mclk_i
// Notes:   Lookup and register answers both arrive one cycle after the request
//
// How it works
// - Upper fixed registers hold eight byte types, low byte lowest 4K page.
// - Eight variable ranges, each one base register and one mask register.
// - Base: type in 7-0, page number in 51-12, other bits zero.
// - Variable types accept standard encodings only; others are refused.
// - Base address low twelve bits are taken as zero.
// - Mask bit 11 enables the pair; clear means ignored.
// - Mask page bits 51-12 stored; all pair fields readable and writable.
// - Hit when mask AND base equals mask AND address page number.
// - Unmatched addresses take the default type.
// - Default register: type 7-0, fixed enable 10, global enable 11.
// - Types: 00 UC, 01 WC, 04 WT, 05 WP, 06 WB.
// - Global enable clear forces uncacheable everywhere.
// - Fixed enable gates fixed ranges only, under global enable.
// - Default type field refuses extended encodings.
`timescale 1ns/1ps
`default_nettype none
module mtl_lookup #(
  parameter int NUM_VAR = 8
) (
  input  wire logic                          mclk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          lookup_req_i,
  input  wire logic [mtl_pkg::PA_W-1:0]      lookup_addr_i,
  input  wire mtl_pkg::mtl_msr_req_t         msr_req_i,
  output logic                               type_valid_o,
  output logic [mtl_pkg::TYP_W-1:0]          mem_type_o,
  output mtl_pkg::mtl_msr_rsp_t              msr_rsp_o
);
  // Configuration state
  logic [mtl_pkg::TYP_W-1:0] var_type_ff [NUM_VAR];
  logic [mtl_pkg::PFN_W-1:0] var_base_ff [NUM_VAR];
  logic [mtl_pkg::PFN_W-1:0] var_mask_ff [NUM_VAR];
  logic [NUM_VAR-1:0]        var_v_ff;
  logic [mtl_pkg::DAT_W-1:0] fix_ff      [mtl_pkg::FIX_REGS];
  logic [mtl_pkg::TYP_W-1:0] def_type_ff;
  logic                      fe_ff;
  logic                      ge_ff;
  logic [mtl_pkg::TYP_W-1:0] nxt_var_type [NUM_VAR];
  logic [mtl_pkg::PFN_W-1:0] nxt_var_base [NUM_VAR];
  logic [mtl_pkg::PFN_W-1:0] nxt_var_mask [NUM_VAR];
  logic [NUM_VAR-1:0]        nxt_var_v;
  logic [mtl_pkg::DAT_W-1:0] nxt_fix      [mtl_pkg::FIX_REGS];
  logic [mtl_pkg::TYP_W-1:0] nxt_def_type;
  logic                      nxt_fe;
  logic                      nxt_ge;
  mtl_pkg::mtl_msr_rsp_t     rsp_ff;
  mtl_pkg::mtl_msr_rsp_t     nxt_rsp;
  // Lookup state
  logic                      tv_ff;
  logic                      nxt_tv;
  logic [mtl_pkg::TYP_W-1:0] mt_ff;
  logic [mtl_pkg::TYP_W-1:0] nxt_mt;
  logic [NUM_VAR-1:0]        var_hit;
  logic [mtl_pkg::PFN_W-1:0] pfn;
  logic                      fix_hit;
  logic [1:0]                fix_sel;
  logic [2:0]                fix_byte;
  logic [mtl_pkg::TYP_W-1:0] fix_type;

  assign pfn      = lookup_addr_i[mtl_pkg::PFN_MSB:mtl_pkg::PFN_LSB];
  // Only the top three 32-Kbyte blocks below 1 Mbyte have fixed types here
  assign fix_hit  = (lookup_addr_i[mtl_pkg::PA_W-1:20] == '0)
                    && (lookup_addr_i[19:15] >= mtl_pkg::FIX_FIRST_BLK);
  assign fix_sel  = 2'(lookup_addr_i[19:15] - mtl_pkg::FIX_FIRST_BLK);
  assign fix_byte = lookup_addr_i[14:12];
  // Byte k of a fixed register types the k-th 4K page of its block
  assign fix_type = fix_ff[fix_sel][fix_byte*8 +: 8];

  // One comparator per variable range
  for (genvar g = 0; g < NUM_VAR; g++) begin : g_match
    mtl_range_match u_match (
      .base_i  (var_base_ff[g]),
      .mask_i  (var_mask_ff[g]),
      .valid_i (var_v_ff[g]),
      .pfn_i   (pfn),
      .hit_o   (var_hit[g])
    );
  end

  // Register writes and reads; a refused write leaves state untouched
  always_comb begin
    logic [mtl_pkg::DAT_W-1:0] d;
    logic                      mapped;
    logic                      bad;
    d            = msr_req_i.data;
    mapped       = 1'b0;
    bad          = 1'b0;
    nxt_var_type = var_type_ff;
    nxt_var_base = var_base_ff;
    nxt_var_mask = var_mask_ff;
    nxt_var_v    = var_v_ff;
    nxt_fix      = fix_ff;
    nxt_def_type = def_type_ff;
    nxt_fe       = fe_ff;
    nxt_ge       = ge_ff;
    nxt_rsp      = '0;
    for (int i = 0; i < NUM_VAR; i++) begin
      if (msr_req_i.idx == 8'(mtl_pkg::IDX_VAR_FIRST + 2*i)) begin
        mapped            = 1'b1;
        nxt_rsp.rdata     = {12'h000, var_base_ff[i], 4'h0, var_type_ff[i]};
        bad               = (d[63:52] != '0) || (d[11:8] != '0)
                            || !mtl_pkg::type_ok(d[7:0]);
        if (msr_req_i.wr && !bad) begin
          nxt_var_type[i] = d[7:0];
          nxt_var_base[i] = d[mtl_pkg::PFN_MSB:mtl_pkg::PFN_LSB];
        end
      end
      if (msr_req_i.idx == 8'(mtl_pkg::IDX_VAR_FIRST + 2*i + 1)) begin
        mapped            = 1'b1;
        nxt_rsp.rdata     = {12'h000, var_mask_ff[i], var_v_ff[i], 11'h000};
        bad               = (d[63:52] != '0) || (d[10:0] != '0);
        if (msr_req_i.wr && !bad) begin
          nxt_var_mask[i] = d[mtl_pkg::PFN_MSB:mtl_pkg::PFN_LSB];
          nxt_var_v[i]    = d[mtl_pkg::MASK_V];
        end
      end
    end
    for (int r = 0; r < mtl_pkg::FIX_REGS; r++) begin
      if (msr_req_i.idx == 8'(mtl_pkg::IDX_FIX_E8 + r)) begin
        mapped        = 1'b1;
        nxt_rsp.rdata = fix_ff[r];
        for (int b = 0; b < 8; b++) begin
          bad = bad || !mtl_pkg::type_ok(d[b*8 +: 8]);
        end
        if (msr_req_i.wr && !bad) begin
          nxt_fix[r] = d;
        end
      end
    end
    if (msr_req_i.idx == mtl_pkg::IDX_DEF_TYPE) begin
      mapped        = 1'b1;
      nxt_rsp.rdata = {52'h0, ge_ff, fe_ff, 2'h0, def_type_ff};
      bad           = (d[63:12] != '0) || (d[9:8] != '0)
                      || !mtl_pkg::type_ok(d[7:0]);
      if (msr_req_i.wr && !bad) begin
        nxt_def_type = d[7:0];
        nxt_fe       = d[mtl_pkg::DEF_FE];
        nxt_ge       = d[mtl_pkg::DEF_GE];
      end
    end
    // Unmapped index faults on read or write; bad data faults on write only
    nxt_rsp.ack   = msr_req_i.wr || msr_req_i.rd;
    nxt_rsp.fault = nxt_rsp.ack && (!mapped || (msr_req_i.wr && bad));
    if (!msr_req_i.rd || !mapped) begin
      nxt_rsp.rdata = '0;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_VAR; i++) begin
        var_type_ff[i] <= mtl_pkg::RST_TYPE;
        var_base_ff[i] <= mtl_pkg::RST_PFN;
        var_mask_ff[i] <= mtl_pkg::RST_PFN;
      end
      for (int r = 0; r < mtl_pkg::FIX_REGS; r++) begin
        fix_ff[r] <= mtl_pkg::RST_FIX;
      end
      var_v_ff    <= '0;
      def_type_ff <= mtl_pkg::RST_TYPE;
      fe_ff       <= 1'b0;
      ge_ff       <= 1'b0;
      rsp_ff      <= '0;
    end else begin
      var_type_ff <= nxt_var_type;
      var_base_ff <= nxt_var_base;
      var_mask_ff <= nxt_var_mask;
      var_v_ff    <= nxt_var_v;
      fix_ff      <= nxt_fix;
      def_type_ff <= nxt_def_type;
      fe_ff       <= nxt_fe;
      ge_ff       <= nxt_ge;
      rsp_ff      <= nxt_rsp;
    end
  end

  // Type resolution: global enable, then fixed, then variable, then default
  always_comb begin
    logic [7:0] seen;
    seen = '0;
    for (int i = 0; i < NUM_VAR; i++) begin
      if (var_hit[i]) begin
        seen[var_type_ff[i][2:0]] = 1'b1;
      end
    end
    nxt_tv = lookup_req_i;
    nxt_mt = mt_ff;
    if (lookup_req_i) begin
      if (!ge_ff) begin
        nxt_mt = mtl_pkg::MT_UC;
      end else if (fe_ff && fix_hit) begin
        nxt_mt = fix_type;
      end else if (seen == '0) begin
        nxt_mt = def_type_ff;
      end else if (seen[mtl_pkg::MT_UC[2:0]]) begin
        nxt_mt = mtl_pkg::MT_UC;
      end else if ($onehot(seen)) begin
        nxt_mt = '0;
        for (int t = 0; t < 8; t++) begin
          if (seen[t]) begin
            nxt_mt = 8'(t);
          end
        end
      end else if (seen == ((8'h01 << mtl_pkg::MT_WT[2:0]) | (8'h01 << mtl_pkg::MT_WB[2:0]))) begin
        nxt_mt = mtl_pkg::MT_WT; // Writethrough is the safe meet of WT and WB
      end else begin
        nxt_mt = mtl_pkg::MT_UC; // Any other conflict falls back to uncacheable
      end
    end
  end

  // Lookup result registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tv_ff <= 1'b0;
      mt_ff <= mtl_pkg::MT_UC;
    end else begin
      tv_ff <= nxt_tv;
      mt_ff <= nxt_mt;
    end
  end

  assign type_valid_o = tv_ff;
  assign mem_type_o   = mt_ff;
  assign msr_rsp_o    = rsp_ff;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  chk_ge_off_uc: assert property (
    lookup_req_i && !ge_ff |=> type_valid_o && mem_type_o == mtl_pkg::MT_UC)
    else $error("Lookup with global enable off not uncacheable");
  chk_default_used: assert property (
    lookup_req_i && ge_ff && !(fe_ff && fix_hit) && var_hit == '0
      |=> mem_type_o == $past(def_type_ff))
    else $error("Unmatched lookup did not give default type");
  chk_fixed_first: assert property (
    lookup_req_i && ge_ff && fe_ff && fix_hit |=> mem_type_o == $past(fix_type))
    else $error("Fixed range did not take precedence");
  chk_fe_gated: assert property (
    lookup_req_i && ge_ff && !fe_ff && var_hit == '0 |=> mem_type_o == $past(def_type_ff))
    else $error("Fixed range used while fixed enable clear");
  chk_uc_wins: assert property (
    lookup_req_i && ge_ff && !(fe_ff && fix_hit) && var_hit[0] && var_hit[1]
      && var_type_ff[1] == mtl_pkg::MT_UC |=> mem_type_o == mtl_pkg::MT_UC)
    else $error("Overlap with uncacheable did not give uncacheable");
  chk_bad_type_kept: assert property (
    msr_req_i.wr && msr_req_i.idx == mtl_pkg::IDX_VAR_FIRST
      && !mtl_pkg::type_ok(msr_req_i.data[7:0])
      |=> msr_rsp_o.fault && $stable(var_type_ff[0]) ##1 $stable(var_type_ff[0]))
    else $error("Extended type accepted in variable base");
  chk_def_rsvd: assert property (
    msr_req_i.wr && msr_req_i.idx == mtl_pkg::IDX_DEF_TYPE && msr_req_i.data[9:8] != 2'h0
      |=> msr_rsp_o.ack && msr_rsp_o.fault && $stable(ge_ff))
    else $error("Default register reserved bits not refused");
  chk_invalid_skip: assert property (
    !var_v_ff[0] |-> !var_hit[0])
    else $error("Disabled variable range matched");
  chk_base_readback: assert property (
    msr_req_i.rd && msr_req_i.idx == mtl_pkg::IDX_VAR_FIRST
      |=> msr_rsp_o.rdata[63:52] == '0 && msr_rsp_o.rdata[11:8] == '0
          && msr_rsp_o.rdata[51:12] == $past(var_base_ff[0]))
    else $error("Base readback wrong");
endmodule
`default_nettype wire

// file: mtl_path_model.sv
// Purpose: Memory access path model that issues lookups and collects types
// Assumes: Lookup answer arrives one cycle after the request edge
// Notes:   Released address shows the inverse of the last one
`timescale 1ns/1ps
`default_nettype none
module mtl_path_model (
  input  wire logic                     mclk_i,
  output logic                          lookup_req_o,
  output logic [mtl_pkg::PA_W-1:0]      lookup_addr_o,
  input  wire logic                     type_valid_i,
  input  wire logic [mtl_pkg::TYP_W-1:0] mem_type_i
);
  initial begin
    lookup_req_o  = 1'b0;
    lookup_addr_o = '0;
  end

  // One lookup, driven on falling edges; answer sampled a full cycle later
  task automatic look(input logic [mtl_pkg::PA_W-1:0] a, output logic [8:0] r);
    @(negedge mclk_i);
    lookup_req_o  = 1'b1;
    lookup_addr_o = a;
    @(negedge mclk_i);
    lookup_req_o  = 1'b0;
    lookup_addr_o = ~a; // Stale address must not be trusted
    r = {type_valid_i, mem_type_i};
  endtask
endmodule
`default_nettype wire

// file: test_mtl_lookup.sv
// Purpose: Self-checking bench for the memory type range lookup block
// Assumes: Register answers and lookups come one cycle after the request
// Notes:   Masks are worked out by hand from range top, base and size
`timescale 1ns/1ps
`default_nettype none
module test_mtl_lookup;
  logic                  mclk_i;
  logic                  reset_n_i;
  logic                  lookup_req_i;
  logic [51:0]           lookup_addr_i;
  mtl_pkg::mtl_msr_req_t msr_req_i;
  logic                  type_valid_o;
  logic [7:0]            mem_type_o;
  mtl_pkg::mtl_msr_rsp_t msr_rsp_o;
  int                    err_total;
  int                    n_compared;
  int                    cyc;
  logic [8:0]            r;
  logic [63:0]           fix;

  mtl_lookup u_mtl_lookup (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .lookup_req_i(lookup_req_i), .lookup_addr_i(lookup_addr_i), .msr_req_i(msr_req_i),
    .type_valid_o(type_valid_o), .mem_type_o(mem_type_o), .msr_rsp_o(msr_rsp_o));
  mtl_path_model u_mtl_path_model (.mclk_i(mclk_i), .lookup_req_o(lookup_req_i),
    .lookup_addr_o(lookup_addr_i), .type_valid_i(type_valid_o), .mem_type_i(mem_type_o));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Tests should finish well within this many cycles
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [65:0] e, input logic [65:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total = err_total + 1;
    end
  endtask

  // Register access; a write answer carries zero read data
  task automatic acc(input logic w, input logic [7:0] idx, input logic [63:0] d,
                     input logic ef, input logic [63:0] er);
    @(negedge mclk_i);
    msr_req_i = '{wr: w, rd: ~w, idx: idx, data: d};
    @(negedge mclk_i);
    msr_req_i = '0;
    check("msr_rsp", {1'b1, ef, er}, {msr_rsp_o.ack, msr_rsp_o.fault, msr_rsp_o.rdata});
  endtask

  task automatic lk(input logic [51:0] a, input logic [7:0] e);
    u_mtl_path_model.look(a, r);
    check("mem_type", {57'h0, 1'b1, e}, {57'h0, r});
  endtask

  initial begin
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    msr_req_i = '0;
    reset_n_i = 1'b0;
    fix = 64'h0605_0401_0006_0504;
    repeat (8) @(negedge mclk_i);
    reset_n_i = 1'b1;
    acc(1'b0, 8'h13, 64'h0, 1'b0, 64'h0);
    lk(52'h0_0000_0200_0000, 8'h00);
    acc(1'b1, 8'h13, 64'h0c04, 1'b0, 64'h0);
    acc(1'b0, 8'h13, 64'h0, 1'b0, 64'h0c04);
    // 32-Mbyte WB range at 200_0000h; mask from top minus base, shifted 12
    acc(1'b1, 8'h00, 64'h0000_0000_0200_0006, 1'b0, 64'h0);
    acc(1'b1, 8'h01, 64'h000f_ffff_fe00_0800, 1'b0, 64'h0);
    // 4-Kbyte UC page inside it, then an invalid pair that would hit all
    acc(1'b1, 8'h02, 64'h0000_0000_0200_1000, 1'b0, 64'h0);
    acc(1'b1, 8'h03, 64'h000f_ffff_ffff_f800, 1'b0, 64'h0);
    acc(1'b1, 8'h04, 64'h0000_0000_0000_0001, 1'b0, 64'h0);
    // Last pair: UC over the first megabyte
    acc(1'b1, 8'h0f, 64'h000f_ffff_fff0_0800, 1'b0, 64'h0);
    acc(1'b1, 8'h10, fix, 1'b0, 64'h0);
    acc(1'b0, 8'h01, 64'h0, 1'b0, 64'h000f_ffff_fe00_0800);
    lk(52'h0_0000_0200_0000, 8'h06);
    lk(52'h0_0000_03ff_ffff, 8'h06);
    lk(52'h0_0000_0400_0000, 8'h04);
    lk(52'h0_0000_0200_1abc, 8'h00);
    lk(52'h0_0000_0001_0000, 8'h00);
    for (int k = 0; k < 8; k++) begin
      lk(52'he8000 + 52'(k) * 52'h1000, fix[8*k+:8]);
    end
    // Top byte of the last fixed register types the last page below 1 Mbyte
    acc(1'b1, 8'h12, 64'h0500_0000_0000_0000, 1'b0, 64'h0);
    lk(52'hff000, 8'h05);
    // Refused writes: reserved bits, bad or extended types, unmapped index
    acc(1'b1, 8'h00, 64'h0000_0000_0200_0106, 1'b1, 64'h0);
    acc(1'b1, 8'h00, 64'h0010_0000_0200_0006, 1'b1, 64'h0);
    acc(1'b1, 8'h00, 64'h0000_0000_0200_0002, 1'b1, 64'h0);
    acc(1'b1, 8'h00, 64'h0000_0000_0200_0018, 1'b1, 64'h0);
    acc(1'b1, 8'h13, 64'h0c10, 1'b1, 64'h0);
    acc(1'b1, 8'h13, 64'h1c04, 1'b1, 64'h0);
    acc(1'b1, 8'h13, 64'h0d04, 1'b1, 64'h0);
    acc(1'b1, 8'h20, 64'h0, 1'b1, 64'h0);
    acc(1'b0, 8'h00, 64'h0, 1'b0, 64'h0000_0000_0200_0006);
    acc(1'b0, 8'h13, 64'h0, 1'b0, 64'h0c04);
    // Fixed enable off: variable ranges take over the fixed region
    acc(1'b1, 8'h13, 64'h0801, 1'b0, 64'h0);
    lk(52'he8000, 8'h00);
    lk(52'h0_0000_0200_0000, 8'h06);
    lk(52'h0_0000_0400_0000, 8'h01);
    // Writethrough pair over the writeback range: the meet is writethrough
    acc(1'b1, 8'h06, 64'h0000_0000_0200_0004, 1'b0, 64'h0);
    acc(1'b1, 8'h07, 64'h000f_ffff_fe00_0800, 1'b0, 64'h0);
    lk(52'h0_0000_0300_0000, 8'h04);
    // Global enable off with fixed enable set again
    acc(1'b1, 8'h13, 64'h0406, 1'b0, 64'h0);
    lk(52'h0_0000_0400_0000, 8'h00);
    lk(52'he9000, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
